//--- pkg/sac_pkg.sv
// shared constants and types for the converter control block
package sac_pkg;

    // result width and code step: one step is vref / 2**16
    localparam int RESULT_BITS = 16;

    // core clock period and conversion time bounds, in ns
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_MIN_NS = 500;
    localparam int CONV_MAX_NS = 710;

    // least time rounds up, longest time rounds down
    localparam int CONV_MIN_CYC =
        (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;

    // default conversion length sits between the two bounds
    localparam int CONV_DEF_CYC = (CONV_MIN_CYC + CONV_MAX_CYC) / 2;

    // decisions resolved per core cycle by the approximation engine
    localparam int SAR_BITS_PER_STEP = 2;

    // falling serial edges after which the output floats
    localparam logic [4:0] FRAME_EDGES_PLAIN = 5'h10;
    localparam logic [4:0] FRAME_EDGES_BUSY = 5'h11;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

    // positions of the pins inside the synchroniser vector
    localparam int PIN_START = 0;
    localparam int PIN_DIN = 1;
    localparam int PIN_COUNT = 2;

    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [4:0] EDGE_CNT_RST = 5'h00;

    // core control states
    typedef enum logic {
        SAC_ACQUIRE,
        SAC_CONVERT
    } sac_state_type;

    // stored result with the options fixed at its conversion
    typedef struct packed {
        logic [15:0] code;    // straight binary result
        logic cs_mode;        // chip-select mode chosen at start
        logic busy_opt;       // leading busy bit requested
        logic valid;          // a conversion has completed
    } sac_result_type;

endpackage : sac_pkg

//--- src/sac_converter_ctrl.sv
// Contract
// - conversion timed by internal clock within bounds
// - serial clock only shifts out result data
// - result is 16-bit unsigned straight binary
// - data input high at start: chip-select mode
// - data input low at start: daisy-chain mode
// - busy option adds one leading indicator bit
// - chip-select mode: three/four wire, busy optional
// - inputs held on sampling array during conversion
// - after conversion reconnect, acquire, power down
// - start edge floats output, samples, converts
// - plain: msb first, float after 16th edge
// - busy: low bit, data, float after 17th
`timescale 1ns/1ps
`default_nettype none

module sac_converter_ctrl #(
    // conversion length in core cycles, kept between the bounds
    parameter int CONV_CYC = sac_pkg::CONV_DEF_CYC
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    // link clock from the host, runs only while reading
    input wire logic sclk_i,
    // start-convert pin, also chip select in three-wire use
    input wire logic start_convert_in_i,
    // serial data in, mode select and four-wire chip select
    input wire logic din_i,
    // digital stand-ins for the two analog inputs
    input wire logic [15:0] positive_analog_input_i,
    input wire logic [15:0] negative_analog_input_i,
    // serial data out as value and active-low enable
    output logic dout_o,
    output logic dout_oe_n_o,
    // sampling array isolated from the input pins
    output logic inputs_held_o,
    // converter powered down in acquisition
    output logic powered_down_o,
    // mode and option latched for the current result
    output logic cs_mode_o,
    output logic busy_opt_o,
    // one-cycle pulse when a new result is stored
    output logic result_ready_o,
    // stored result, for observation inside the chip
    output logic [15:0] result_o
);

    localparam int W = sac_pkg::RESULT_BITS;
    localparam int NP = sac_pkg::PIN_COUNT;

    // ------------------------------------------------------------
    // pin synchronisers into the core domain
    // ------------------------------------------------------------

    logic [NP-1:0] pin_raw;     // the asynchronous pins
    logic [NP-1:0] sync_a;      // first stage, read by sync_b only
    logic [NP-1:0] sync_b;      // second stage
    logic [NP-1:0] sync_c;      // third stage
    logic [NP-1:0] pin_lvl;     // filtered level of each pin
    logic [NP-1:0] pin_rise;    // accepted rising change
    logic [NP-1:0] pin_fall;    // accepted falling change

    assign pin_raw[sac_pkg::PIN_START] = start_convert_in_i;
    assign pin_raw[sac_pkg::PIN_DIN] = din_i;

    // one synchroniser per pin; a change counts once b and c agree
    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_sync
            // three flops, then the filtered level
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                    pin_lvl[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    // glitch of one sample is not taken
                    if (sync_b[gi] == sync_c[gi]) begin
                        pin_lvl[gi] <= sync_c[gi];
                    end
                end
            end
            // edges seen against the filtered level
            assign pin_rise[gi] = (sync_b[gi] == sync_c[gi])
                                  && sync_c[gi] && !pin_lvl[gi];
            assign pin_fall[gi] = (sync_b[gi] == sync_c[gi])
                                  && !sync_c[gi] && pin_lvl[gi];
        end
    endgenerate

    // named views of the synchronised pins
    wire start_lvl = pin_lvl[sac_pkg::PIN_START];
    wire din_lvl = pin_lvl[sac_pkg::PIN_DIN];
    wire start_edge = pin_rise[sac_pkg::PIN_START];
    // data input level at the start edge, from the same stage
    wire din_at_start = sync_c[sac_pkg::PIN_DIN];

    // ------------------------------------------------------------
    // core state: acquisition and conversion
    // ------------------------------------------------------------

    sac_pkg::sac_state_type state;      // current phase
    sac_pkg::sac_state_type next_state; // phase for next cycle
    sac_pkg::sac_result_type held;      // stored result and options
    logic [15:0] samp_pos;              // positive input on array
    logic [15:0] samp_neg;              // negative input on array
    logic [7:0] conv_cnt;               // cycles into conversion
    logic mode_cs;                      // mode of conversion underway
    logic sar_start;                    // kicks off the search
    logic sar_done;                     // search has finished
    logic [W-1:0] sar_code;             // code from the search
    logic ready_pulse;                  // result stored this cycle

    // difference of the held inputs, clamped at zero code
    wire [15:0] samp_diff = (samp_pos >= samp_neg)
                            ? (samp_pos - samp_neg) : 16'h0000;

    // chip select seen by the core, active high here
    // cs mode: low on start pin (3-wire) or on data in (4-wire)
    // daisy mode: the start pin alone acts as the select
    wire cs_active = held.cs_mode ? !(start_lvl && din_lvl)
                                  : !start_lvl;

    // same select while converting, for the busy decision
    wire cs_active_conv = mode_cs ? !(start_lvl && din_lvl)
                                  : !start_lvl;

    // conversion ends on the internal count, once the search has also finished
    wire conv_end = (state == sac_pkg::SAC_CONVERT)
                    && (conv_cnt == 8'(CONV_CYC - 1))
                    && sar_done;

    // start taken only in acquisition; edges while busy are dropped
    wire start_take = (state == sac_pkg::SAC_ACQUIRE)
                      && start_edge;

    assign sar_start = start_take;

    // next phase
    always_comb begin
        next_state = state;
        case (state)
            sac_pkg::SAC_ACQUIRE: begin
                if (start_take) begin
                    next_state = sac_pkg::SAC_CONVERT;
                end
            end
            sac_pkg::SAC_CONVERT: begin
                // back to acquisition, powered down
                if (conv_end) begin
                    next_state = sac_pkg::SAC_ACQUIRE;
                end
            end
            default: begin
                next_state = sac_pkg::SAC_ACQUIRE;
            end
        endcase
    end

    // phase register and conversion counter
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= sac_pkg::SAC_ACQUIRE;
            conv_cnt <= 8'h00;
        end else begin
            state <= next_state;
            // counts only while converting
            if (start_take) begin
                conv_cnt <= 8'h00;
            end else if (state == sac_pkg::SAC_CONVERT) begin
                conv_cnt <= conv_cnt + 8'h01;
            end
        end
    end

    // capture the inputs and the mode at the start edge
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            samp_pos <= sac_pkg::RESULT_RST;
            samp_neg <= sac_pkg::RESULT_RST;
            mode_cs <= 1'b0;
        end else if (start_take) begin
            // both inputs frozen until the conversion ends
            samp_pos <= positive_analog_input_i;
            samp_neg <= negative_analog_input_i;
            // high: chip-select mode, low: daisy-chain
            mode_cs <= din_at_start;
        end
    end

    // store the result and fix the options for its read
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            held.code <= sac_pkg::RESULT_RST;
            held.cs_mode <= 1'b0;
            held.busy_opt <= 1'b0;
            held.valid <= 1'b0;
            ready_pulse <= 1'b0;
        end else begin
            ready_pulse <= conv_end;
            if (start_take) begin
                // old result no longer readable once sampling
                held.valid <= 1'b0;
            end else if (conv_end) begin
                held.code <= sar_code;
                held.cs_mode <= mode_cs;
                // select still low at the end asks for busy
                held.busy_opt <= cs_active_conv;
                held.valid <= 1'b1;
            end
        end
    end

    // the search itself, a few decisions per core cycle
    sac_sar_engine #(
        .WIDTH(W),
        .PER_STEP(sac_pkg::SAR_BITS_PER_STEP)
    ) u_sar (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .start_i(sar_start),
        .target_i(samp_diff),
        .done_o(sar_done),
        .code_o(sar_code)
    );

    // ------------------------------------------------------------
    // link side: falling edges of the serial clock
    // ------------------------------------------------------------

    logic [4:0] edge_cnt;   // falling edges in this read frame
    logic link_done;        // frame length reached, output floats

    // frame is cleared while the select pins say idle; the serial
    // clock stands still between frames, so no edge can do this
    wire cs_idle_pins = held.cs_mode
                        ? (start_convert_in_i && din_i)
                        : start_convert_in_i;
    wire frame_clr = !resetn_i || cs_idle_pins;

    // held result and options are steady through a whole read,
    // since they change only at a conversion end
    wire [4:0] frame_len = held.busy_opt
                           ? sac_pkg::FRAME_EDGES_BUSY
                           : sac_pkg::FRAME_EDGES_PLAIN;

    // count falling edges; used only for shifting data
    always_ff @(negedge sclk_i or posedge frame_clr) begin
        if (frame_clr) begin
            edge_cnt <= sac_pkg::EDGE_CNT_RST;
            link_done <= 1'b0;
        end else if (!link_done) begin
            edge_cnt <= edge_cnt + 5'h01;
            // float after the 16th or 17th edge
            if (edge_cnt == frame_len - 5'h01) begin
                link_done <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------

    // position in the word: busy frames lead with one extra bit
    wire [4:0] bit_pos = held.busy_opt ? edge_cnt
                                       : edge_cnt + 5'h01;
    wire [4:0] bit_idx = 5'h10 - bit_pos;

    // busy slot is low, then msb first down to lsb
    wire data_bit = (bit_pos == 5'h00) ? 1'b0
                    : held.code[bit_idx[3:0]];

    // drive only in acquisition with a valid result and select low
    // a start edge leaves acquisition and floats the pin
    // idle pins also gate it: the synced select lags, and the
    // cleared frame count must not re-enable the pin meanwhile
    wire drive = (state == sac_pkg::SAC_ACQUIRE) && held.valid
                 && cs_active && !cs_idle_pins
                 && !link_done;

    assign dout_o = drive ? data_bit : 1'b0;
    assign dout_oe_n_o = !drive;

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------

    // array isolated while converting
    assign inputs_held_o = (state == sac_pkg::SAC_CONVERT);
    // powered down whenever acquiring
    assign powered_down_o = (state == sac_pkg::SAC_ACQUIRE);
    assign cs_mode_o = held.cs_mode;
    assign busy_opt_o = held.busy_opt;
    assign result_ready_o = ready_pulse;
    assign result_o = held.code;

endmodule // sac_converter_ctrl

`default_nettype wire

//--- src/sac_sar_engine.sv
`timescale 1ns/1ps
`default_nettype none

// successive approximation engine, a few decisions per clock
module sac_sar_engine #(
    parameter int WIDTH = sac_pkg::RESULT_BITS,
    parameter int PER_STEP = sac_pkg::SAR_BITS_PER_STEP
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [WIDTH-1:0] target_i,
    output logic done_o,
    output logic [WIDTH-1:0] code_o
);

    localparam int STEPS = WIDTH / PER_STEP;

    logic [WIDTH-1:0] acc;         // bits decided so far
    logic [WIDTH-1:0] next_acc;    // after this cycle's decisions
    logic [WIDTH-1:0] probe;       // mask of the next bit to try
    logic [WIDTH-1:0] next_probe;  // mask after this cycle
    logic running;                 // a search is in progress
    logic [7:0] step;              // cycles spent searching

    // try PER_STEP bits this cycle, keeping each that fits
    always_comb begin
        logic [WIDTH-1:0] trial;
        trial = '0;
        next_acc = acc;
        next_probe = probe;
        for (int k = 0; k < PER_STEP; k++) begin
            trial = next_acc | next_probe;
            // the comparator: keep the bit when not above the input
            if (trial <= target_i) begin
                next_acc = trial;
            end
            next_probe = next_probe >> 1;
        end
    end

    // search bookkeeping, restarted by every start pulse
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc <= '0;
            probe <= '0;
            running <= 1'b0;
            step <= 8'h00;
            done_o <= 1'b0;
        end else if (start_i) begin
            acc <= '0;
            probe <= {1'b1, {(WIDTH-1){1'b0}}};
            running <= 1'b1;
            step <= 8'h00;
            done_o <= 1'b0;
        end else if (running) begin
            acc <= next_acc;
            probe <= next_probe;
            step <= step + 8'h01;
            // last group of bits decided this cycle
            if (step == 8'(STEPS - 1)) begin
                running <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end

    // code holds once the search stops
    assign code_o = acc;

endmodule // sac_sar_engine

`default_nettype wire

//--- tb/sac_converter_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port checker for the converter control block
module sac_converter_ctrl_sva #(
    parameter int CONV_CYC = 12
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic start_convert_in_i,
    input wire logic din_i,
    input wire logic [15:0] positive_analog_input_i,
    input wire logic [15:0] negative_analog_input_i,
    input wire logic dout_o,
    input wire logic dout_oe_n_o,
    input wire logic inputs_held_o,
    input wire logic powered_down_o,
    input wire logic cs_mode_o,
    input wire logic busy_opt_o,
    input wire logic result_ready_o,
    input wire logic [15:0] result_o
);
    // conversion time bounds in core cycles
    localparam int LO_CYC = sac_pkg::CONV_MIN_CYC;
    localparam int HI_CYC = sac_pkg::CONV_MAX_CYC;
    logic [4:0] held_cnt; // cycles spent converting
    logic [16:0] diff; // input difference, borrow on top
    assign diff = {1'b0, positive_analog_input_i}
        - {1'b0, negative_analog_input_i};
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // count conversion cycles; a stuck flag wraps, which also fails
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            held_cnt <= 5'h00;
        end else if (inputs_held_o) begin
            held_cnt <= held_cnt + 5'h01;
        end else begin
            held_cnt <= 5'h00;
        end
    end
    held_len_a: assert property (
        $fell(inputs_held_o) |-> held_cnt == 5'(CONV_CYC))
        else $error("conversion length wrong");
    conv_bound_a: assert property (
        $rose(inputs_held_o) |-> ##[LO_CYC:HI_CYC] !inputs_held_o)
        else $error("conversion outside time bounds");
    power_held_a: assert property (
        powered_down_o != inputs_held_o)
        else $error("power state and hold disagree");
    ready_after_a: assert property (
        $fell(inputs_held_o) |-> result_ready_o ##1 !result_ready_o)
        else $error("ready pulse missing after conversion");
    ready_cause_a: assert property (
        $rose(result_ready_o) |->
            $past(inputs_held_o) && !inputs_held_o)
        else $error("ready pulse without conversion end");
    float_conv_a: assert property (
        inputs_held_o |-> dout_oe_n_o)
        else $error("output driven during conversion");
    start_take_a: assert property (
        $rose(start_convert_in_i) && powered_down_o
            |-> ##[2:6] inputs_held_o)
        else $error("start edge not taken");
    result_code_a: assert property (
        result_ready_o |-> result_o == (diff[16] ? 16'h0000 : diff[15:0]))
        else $error("result code wrong");
    busy_bit_a: assert property (
        $fell(dout_oe_n_o) && busy_opt_o |-> !dout_o)
        else $error("busy bit not low");
endmodule // sac_converter_ctrl_sva
bind sac_converter_ctrl sac_converter_ctrl_sva #(.CONV_CYC(CONV_CYC))
    i_sac_converter_ctrl_sva (.clock_i(clock_i), .resetn_i(resetn_i),
    .sclk_i(sclk_i), .start_convert_in_i(start_convert_in_i),
    .din_i(din_i), .positive_analog_input_i(positive_analog_input_i),
    .negative_analog_input_i(negative_analog_input_i), .dout_o(dout_o),
    .dout_oe_n_o(dout_oe_n_o), .inputs_held_o(inputs_held_o),
    .powered_down_o(powered_down_o), .cs_mode_o(cs_mode_o),
    .busy_opt_o(busy_opt_o), .result_ready_o(result_ready_o),
    .result_o(result_o));
`default_nettype wire

//--- tb/sac_converter_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sac_converter_ctrl_tb;
    localparam int CONV = 10; // shortest legal conversion
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic start_pin = 1'b0; // start pin, also select in three-wire use
    logic din_pin = 1'b1; // mode select, select in four-wire use
    logic [15:0] pos_code = 16'h0000;
    logic [15:0] neg_code = 16'h0000;
    logic dout, oe_n, held, pdn, csm, bopt, rdy, sclk, go, done, floated;
    logic [15:0] res, exp_code;
    logic [16:0] bits;
    logic [4:0] n_edges = 5'h00;
    logic last_busy = 1'b0; // busy option expected for stored result
    int num_errors = 0;
    int compares = 0;
    always #25 clock_i = ~clock_i;
    sac_converter_ctrl #(.CONV_CYC(CONV)) i_sac_converter_ctrl (
        .clock_i(clock_i), .resetn_i(resetn_i), .sclk_i(sclk),
        .start_convert_in_i(start_pin), .din_i(din_pin),
        .positive_analog_input_i(pos_code),
        .negative_analog_input_i(neg_code), .dout_o(dout),
        .dout_oe_n_o(oe_n), .inputs_held_o(held), .powered_down_o(pdn),
        .cs_mode_o(csm), .busy_opt_o(bopt), .result_ready_o(rdy),
        .result_o(res));
    sac_host_model i_sac_host_model (.go_i(go), .edges_i(n_edges),
        .dout_i(dout), .dout_oe_n_i(oe_n), .sclk_o(sclk), .bits_o(bits),
        .floated_o(floated), .done_o(done));
    task automatic check(input string what, input logic [16:0] seen,
        input logic [16:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // start a conversion; select levels are held until it ends
    task automatic convert(input logic mode_din, input logic sel_start,
        input logic sel_din, input logic [15:0] p, input logic [15:0] n,
        input logic busy);
        int k;
        pos_code = p;
        neg_code = n;
        din_pin = mode_din;
        start_pin = 1'b0;
        cyc(3);
        start_pin = 1'b1; // rising edge starts the conversion
        cyc(5);
        start_pin = sel_start;
        din_pin = sel_din;
        exp_code = (p > n) ? p - n : 16'h0000;
        last_busy = busy;
        k = 0;
        while (rdy !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        if (k == 40) begin
            num_errors++;
            test_done();
        end
        check("mode", {16'h0000, csm}, {16'h0000, mode_din});
        check("busy option", {16'h0000, bopt}, {16'h0000, busy});
        check("result", {1'b0, res}, {1'b0, exp_code});
    endtask
    // select the device and clock n falling edges out of it
    task automatic read(input logic rd_start, input logic rd_din,
        input logic [4:0] n);
        int k;
        int full;
        full = last_busy ? 17 : 16;
        start_pin = rd_start;
        din_pin = rd_din;
        cyc(6);
        n_edges = n;
        go = 1'b1;
        k = 0;
        while (done !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        if (k == 100) begin
            num_errors++;
            test_done();
        end
        go = 1'b0;
        cyc(1);
        check("frame", bits, {1'b0, exp_code} >> (full - n));
        check("float", {16'h0000, floated}, 17'(n == full));
    endtask
    initial begin
        go = 1'b0;
        repeat (4) @(negedge clock_i);
        resetn_i = 1'b1;
        cyc(2);
        // three-wire, plain then busy
        convert(1'b1, 1'b1, 1'b1, 16'h9abc, 16'h0123, 1'b0);
        read(1'b0, 1'b1, 5'h10);
        convert(1'b1, 1'b0, 1'b1, 16'h8001, 16'h0000, 1'b1);
        read(1'b0, 1'b1, 5'h11);
        // four-wire, plain then busy with a clamped result
        convert(1'b1, 1'b1, 1'b1, 16'hffff, 16'h0000, 1'b0);
        read(1'b1, 1'b0, 5'h10);
        convert(1'b1, 1'b1, 1'b0, 16'h0005, 16'h0009, 1'b1);
        read(1'b1, 1'b0, 5'h11);
        // daisy-chain mode, plain then busy
        convert(1'b0, 1'b1, 1'b0, 16'h5a5a, 16'h0a0a, 1'b0);
        read(1'b0, 1'b0, 5'h10);
        convert(1'b0, 1'b0, 1'b0, 16'h7fff, 16'h0001, 1'b1);
        read(1'b0, 1'b0, 5'h11);
        // frame cut short by deselect must float the output
        convert(1'b1, 1'b1, 1'b1, 16'hc3c3, 16'h0003, 1'b0);
        read(1'b1, 1'b0, 5'h08);
        din_pin = 1'b1;
        cyc(6);
        check("float on deselect", {16'h0000, oe_n}, 17'h00001);
        test_done();
    end
endmodule // sac_converter_ctrl_tb
`default_nettype wire

//--- tb/sac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the serial read; makes the 48 ns link clock
module sac_host_model (
    input wire logic go_i,
    input wire logic [4:0] edges_i,
    input wire logic dout_i,
    input wire logic dout_oe_n_i,
    output logic sclk_o,
    output logic [16:0] bits_o,
    output logic floated_o,
    output logic done_o
);
    logic line_lvl; // level on the shared data line
    // pull-up holds the line high once the device lets go
    assign line_lvl = dout_oe_n_i ? 1'b1 : dout_i;
    initial begin
        sclk_o = 1'b0;
        bits_o = 17'h00000;
        floated_o = 1'b0;
        done_o = 1'b0;
    end
    // one frame per request; clock stands still between frames
    always begin
        wait (go_i);
        bits_o = 17'h00000;
        for (int i = 0; i < edges_i; i++) begin
            sclk_o = 1'b1;
            bits_o = {bits_o[15:0], line_lvl};
            #24;
            sclk_o = 1'b0; // device shifts on this edge
            #24;
        end
        floated_o = dout_oe_n_i;
        done_o = 1'b1;
        wait (!go_i);
        done_o = 1'b0;
    end
endmodule // sac_host_model
`default_nettype wire
